// ---- common/atrc_pkg.sv ----
// Purpose: shared constants for the trim register link
// Assumes: 40 MHz aclk, serial link sampled in aclk domain
// Notes:   frame is header, address, data, MSB first
package atrc_pkg;
    localparam int          FRAME_BITS      = 32;
    localparam int          HDR_BITS        = 12;
    localparam logic [11:0] HDR_PATTERN     = 12'h001;
    localparam logic [3:0]  ADDR_CONFIG     = 4'h1;
    localparam logic [3:0]  ADDR_OFFSET     = 4'h2;
    localparam logic [3:0]  ADDR_FULLSCALE  = 4'h3;
    localparam logic [15:0] OFFSET_RESET    = 16'h007F;
    localparam logic [15:0] FULLSCALE_RESET = 16'h807F;
    localparam logic [15:0] CONFIG_RESET    = 16'hB2FF;
    localparam logic [6:0]  LOW_ONES        = 7'h7F;
    localparam int          OFS_MAG_MSB     = 15;
    localparam int          OFS_MAG_LSB     = 8;
    localparam int          OFS_SIGN_BIT    = 7;
    localparam int          FS_MSB          = 15;
    localparam int          FS_LSB          = 7;
    localparam int          CFG_SDR_BIT     = 10;
    localparam int          CFG_EDGE_BIT    = 8;
    localparam logic [8:0]  FS_NOMINAL      = 9'h100;
    localparam logic [8:0]  FS_LIMIT_LO     = 9'h0C0;
    localparam logic [8:0]  FS_LIMIT_HI     = 9'h1C0;
    localparam int          CLK_MHZ         = 40;
    localparam int          SCLK_NS         = 200;
    localparam int          SCLK_HALF_CYC   = (SCLK_NS * CLK_MHZ / 1000) / 2;
    localparam int          LAT_CYC         = 2;
    localparam logic [3:0]  AXI_CTRL        = 4'h0;
    localparam logic [3:0]  AXI_OFFSET      = 4'h4;
    localparam logic [3:0]  AXI_FULLSCALE   = 4'h8;
    localparam logic [3:0]  AXI_STATUS      = 4'hC;
    localparam logic [1:0]  RESP_OKAY       = 2'b00;
    localparam logic [1:0]  RESP_SLVERR     = 2'b10;
endpackage

// ---- common/atrc_link_if.sv ----
// Purpose: serial trim link plus resync and calibration status
// Assumes: all wires driven by one end each
// Notes:   no two-way pins on this link
`timescale 1ns/1ps
`default_nettype none
interface atrc_link_if;
    logic serial_clk;
    logic serial_input_line;
    logic serial_select_n;
    logic out_clock_resync;
    logic calibration_running;
    modport device (
        input  serial_clk, serial_input_line, serial_select_n, out_clock_resync,
        output calibration_running
    );
    modport host (
        output serial_clk, serial_input_line, serial_select_n, out_clock_resync,
        input  calibration_running
    );
endinterface
`default_nettype wire

// ---- src/atrc_sync2.sv ----
// Purpose: two-flop synchroniser for one level
// Assumes: destination clock aclk
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module atrc_sync2 (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Level
    input  wire logic d,
    output logic      q
);
    logic s1_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q <= 1'b0;
            q    <= 1'b0;
        end else begin
            s1_q <= d;
            q    <= s1_q;
        end
    end
endmodule
`default_nettype wire

// ---- src/atrc_device.sv ----
// Purpose: trim registers, serial receiver and output clock resync
// Assumes: link pins asynchronous to aclk, aclk is the sampling clock
// Notes:   analog effects appear as digital trim outputs
//
// Contract
// - Offset magnitude from bits 15:8, linear
// - Bit 7 is offset sign, 1 negative
// - Host writes ones in bits 6:0
// - Full-scale from bits 15:7, linear
// - Host keeps full-scale in recommended range
// - Gain change needs no recalibration
// - Full-scale resets to no adjustment
// - Plus and minus zero offset differ
// - Resync async assert holds data clock; here it passes the two-flop synchroniser and holds from the third aclk edge
// - Release on rise, align next fall
// - Restart after fixed normal latency
// - No resync while calibration runs
// - Clip out of range, flag while out
// - Output code is offset binary
// - Range from pin or register by mode
// - 32-bit frame, header, address, data
// - Trims only act in extended mode
// - Next frame may start at 33rd clock
// - No serial writes during calibration
`timescale 1ns/1ps
`default_nettype none
module atrc_device
    import atrc_pkg::*;
(
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Link
    atrc_link_if.device     link,
    // Mode and analog-side controls
    input  wire logic       extended_mode,
    input  wire logic       range_select_pin,
    input  wire logic       output_edge_select,
    input  wire logic       calibrate_start,
    // Converter core samples, signed differential, 10 bits with headroom
    input  wire logic [9:0] sample_in,
    // Trim outputs
    output logic [7:0]      offset_magnitude,
    output logic            offset_negative,
    output logic [8:0]      full_scale_code,
    output logic            full_scale_from_pin,
    // Data path
    output logic [7:0]      data_out,
    output logic            out_of_range,
    output logic            data_clock_output
);
    logic sclk_s, serial_input_line_s, scs_n_s, rst_s, sclk_prev_q;
    atrc_sync2 u_sclk  (.aclk(aclk), .aresetn(aresetn), .d(link.serial_clk),        .q(sclk_s));
    atrc_sync2 u_serial_input_line (.aclk(aclk), .aresetn(aresetn), .d(link.serial_input_line), .q(serial_input_line_s));
    atrc_sync2 u_scs   (.aclk(aclk), .aresetn(aresetn), .d(link.serial_select_n),   .q(scs_n_s));
    atrc_sync2 u_rst   (.aclk(aclk), .aresetn(aresetn), .d(link.out_clock_resync),  .q(rst_s));

    logic sclk_rise;
    assign sclk_rise = sclk_s && !sclk_prev_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) sclk_prev_q <= 1'b0;
        else          sclk_prev_q <= sclk_s;
    end

    // Serial receiver
    logic [31:0] shift_q;
    logic [5:0]  count_q;
    logic        frame_done;
    logic [31:0] frame_word;
    assign frame_word = {shift_q[30:0], serial_input_line_s};
    assign frame_done = sclk_rise && !scs_n_s && (count_q == 6'(FRAME_BITS - 1));
    always_ff @(posedge aclk) begin
        if (!aresetn || scs_n_s) begin
            shift_q <= '0;
            count_q <= '0;
        end else if (sclk_rise) begin
            shift_q <= frame_word;
            // Back-to-back frames without deselect
            count_q <= frame_done ? 6'd0 : count_q + 6'd1;
        end
    end

    // Trim registers, written only by a full valid frame
    logic [15:0] offset_q, fullscale_q, config_q;
    logic        hdr_ok;
    logic [3:0]  waddr;
    assign hdr_ok = (frame_word[31:20] == HDR_PATTERN);
    assign waddr  = frame_word[19:16];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            offset_q    <= OFFSET_RESET;
            fullscale_q <= FULLSCALE_RESET;
            config_q    <= CONFIG_RESET;
        end else if (frame_done && hdr_ok) begin
            // Reserved addresses fall through untouched
            unique case (waddr)
                ADDR_CONFIG:    config_q    <= frame_word[15:0];
                ADDR_OFFSET:    offset_q    <= frame_word[15:0];
                ADDR_FULLSCALE: fullscale_q <= frame_word[15:0];
                default: ;
            endcase
        end
    end

    // Trim outputs act only in extended mode
    always_comb begin
        if (extended_mode) begin
            offset_magnitude = offset_q[OFS_MAG_MSB:OFS_MAG_LSB];
            offset_negative  = offset_q[OFS_SIGN_BIT];
            // Applied live, no recalibration request
            full_scale_code  = fullscale_q[FS_MSB:FS_LSB];
            full_scale_from_pin = 1'b0;
        end else begin
            offset_magnitude = 8'h00;
            offset_negative  = 1'b0;
            full_scale_code  = range_select_pin ? FS_NOMINAL : FS_LIMIT_LO;
            full_scale_from_pin = 1'b1;
        end
    end

    // Calibration status, a short fixed run
    logic [3:0] cal_cnt_q;
    always_ff @(posedge aclk) begin
        if (!aresetn)                cal_cnt_q <= 4'h0;
        else if (cal_cnt_q != 4'h0)  cal_cnt_q <= cal_cnt_q - 4'h1;
        else if (calibrate_start)    cal_cnt_q <= 4'hF;
    end
    assign link.calibration_running = (cal_cnt_q != 4'h0);

    // Clip and offset binary coding
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_out     <= 8'h80;
            out_of_range <= 1'b0;
        end else if ($signed(sample_in) > 10'sd127) begin
            data_out     <= 8'hFF;
            out_of_range <= 1'b1;
        end else if ($signed(sample_in) < -10'sd128) begin
            data_out     <= 8'h00;
            out_of_range <= 1'b1;
        end else begin
            data_out     <= {~sample_in[7], sample_in[6:0]};
            out_of_range <= 1'b0;
        end
    end

    // Data clock, divided by two from aclk, resynchronised
    logic       sdr_mode, hold_level, rst_prev_q, data_clock_output_q;
    logic [1:0] lat_q;
    assign sdr_mode   = extended_mode ? config_q[CFG_SDR_BIT] : 1'b0;
    assign hold_level = sdr_mode ?
        ~(extended_mode ? config_q[CFG_EDGE_BIT] : output_edge_select) : 1'b0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_prev_q <= 1'b0;
            lat_q      <= '0;
            data_clock_output_q     <= 1'b0;
        end else begin
            rst_prev_q <= rst_s;
            if (rst_s) begin
                data_clock_output_q <= hold_level;
                lat_q  <= '0;
            end else if (rst_prev_q) begin
                // Release edge: start the fixed restart latency
                lat_q  <= 2'(LAT_CYC);
                data_clock_output_q <= hold_level;
            end else if (lat_q != 2'd0) begin
                lat_q  <= lat_q - 2'd1;
                data_clock_output_q <= hold_level;
            end else begin
                data_clock_output_q <= ~data_clock_output_q;
            end
        end
    end
    assign data_clock_output = data_clock_output_q;
endmodule
`default_nettype wire

// ---- src/atrc_host.sv ----
// Purpose: AXI4-Lite controlled host driving the trim link
// Assumes: one AXI write and one read at a time
// Notes:   serial clock divided from aclk, no second domain
`timescale 1ns/1ps
`default_nettype none
module atrc_host
    import atrc_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite slave
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Link
    atrc_link_if.host        link
);
    typedef enum logic [1:0] {
        ATRC_IDLE  = 2'b00,
        ATRC_SHIFT = 2'b01,
        ATRC_DONE  = 2'b10
    } atrc_state_t;

    logic        cal_s;
    atrc_sync2 u_cal (.aclk(aclk), .aresetn(aresetn), .d(link.calibration_running), .q(cal_s));

    logic [15:0] offset_q, fullscale_q;
    logic        busy_q, refused_q;
    logic [1:0]  send_q;
    logic        resync_q;

    // AXI write: both channels taken together
    logic wr_go, wr_ok;
    assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_wready  = s_axi_awready;
    assign wr_go = s_axi_awready;
    assign wr_ok = (s_axi_awaddr == AXI_CTRL) || (s_axi_awaddr == AXI_OFFSET)
                || (s_axi_awaddr == AXI_FULLSCALE);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Bits 6:0 forced to ones on every stored offset or full-scale write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            offset_q    <= OFFSET_RESET;
            fullscale_q <= FULLSCALE_RESET;
        end else if (wr_go && s_axi_wstrb[1] && s_axi_wstrb[0]) begin
            if (s_axi_awaddr == AXI_OFFSET)
                offset_q <= {s_axi_wdata[15:7], LOW_ONES};
            if (s_axi_awaddr == AXI_FULLSCALE)
                fullscale_q <= {s_axi_wdata[15:7], LOW_ONES};
        end
    end

    // Control: bit0 send offset, bit1 send full-scale, bit2 resync level
    logic cmd_send, cmd_blocked;
    assign cmd_send    = wr_go && (s_axi_awaddr == AXI_CTRL) && (s_axi_wdata[1:0] != 2'b00);
    assign cmd_blocked = cal_s || busy_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            resync_q  <= 1'b0;
            refused_q <= 1'b0;
        end else if (wr_go && (s_axi_awaddr == AXI_CTRL)) begin
            // Resync refused while calibrating
            resync_q  <= s_axi_wdata[2] && !cal_s;
            refused_q <= cal_s && (s_axi_wdata[2] || cmd_send);
        end else if (cal_s && resync_q) begin
            resync_q  <= 1'b0;
        end
    end

    // Serial engine
    atrc_state_t state_q;
    logic [31:0] frame_q;
    logic [5:0]  bit_q;
    logic [2:0]  div_q;
    logic        sclk_q, tick;
    assign tick = (div_q == 3'(SCLK_HALF_CYC - 1));
    always_ff @(posedge aclk) begin
        if (!aresetn || state_q != ATRC_SHIFT) div_q <= '0;
        else if (tick)                         div_q <= '0;
        else                                   div_q <= div_q + 3'd1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ATRC_IDLE;
            send_q  <= 2'b00;
            busy_q  <= 1'b0;
            frame_q <= '0;
            bit_q   <= '0;
            sclk_q  <= 1'b0;
        end else begin
            unique case (state_q)
                ATRC_IDLE: begin
                    if (cmd_send && !cmd_blocked) begin
                        send_q <= s_axi_wdata[1:0];
                        busy_q <= 1'b1;
                    end else if (send_q[0]) begin
                        frame_q <= {HDR_PATTERN, ADDR_OFFSET, offset_q};
                        send_q[0] <= 1'b0;
                        bit_q   <= '0;
                        state_q <= ATRC_SHIFT;
                    end else if (send_q[1]) begin
                        // Range kept to the recommended window
                        frame_q <= {HDR_PATTERN, ADDR_FULLSCALE,
                            (fullscale_q[15:7] < FS_LIMIT_LO) ? {FS_LIMIT_LO, LOW_ONES} :
                            (fullscale_q[15:7] > FS_LIMIT_HI) ? {FS_LIMIT_HI, LOW_ONES} :
                            fullscale_q};
                        send_q[1] <= 1'b0;
                        bit_q   <= '0;
                        state_q <= ATRC_SHIFT;
                    end else begin
                        busy_q <= 1'b0;
                    end
                end
                ATRC_SHIFT: begin
                    if (tick) begin
                        sclk_q <= ~sclk_q;
                        if (sclk_q) begin
                            frame_q <= {frame_q[30:0], 1'b0};
                            bit_q   <= bit_q + 6'd1;
                            if (bit_q == 6'(FRAME_BITS - 1)) state_q <= ATRC_DONE;
                        end
                    end
                end
                ATRC_DONE: begin
                    state_q <= ATRC_IDLE;
                end
                default: state_q <= ATRC_IDLE;
            endcase
        end
    end
    assign link.serial_clk        = sclk_q;
    assign link.serial_input_line = frame_q[31];
    assign link.serial_select_n   = (state_q != ATRC_SHIFT);
    assign link.out_clock_resync  = resync_q;

    // AXI read
    logic [31:0] rd_d;
    logic        rd_ok;
    assign s_axi_arready = !s_axi_rvalid;
    always_comb begin
        rd_ok = 1'b1;
        unique case (s_axi_araddr)
            AXI_CTRL:      rd_d = {29'h0, resync_q, 2'b00};
            AXI_OFFSET:    rd_d = {16'h0, offset_q};
            AXI_FULLSCALE: rd_d = {16'h0, fullscale_q};
            AXI_STATUS:    rd_d = {29'h0, refused_q, cal_s, busy_q};
            default: begin
                rd_d  = 32'h0;
                rd_ok = 1'b0;
            end
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_d;
            s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- tb/atrc_chk.sv ----
// Purpose: link protocol assertions between host and device
// Assumes: every link wire sampled on aclk
// Notes:   serial clock half period is four aclk cycles
`timescale 1ns/1ps
`default_nettype none
module atrc_chk (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Link
    input  wire logic serial_clk,
    input  wire logic serial_input_line,
    input  wire logic serial_select_n,
    input  wire logic out_clock_resync,
    input  wire logic calibration_running
);
    logic [6:0] rise_q;
    logic       sclk_q;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Rises per frame, cleared whenever select is high
    always_ff @(posedge aclk) begin
        if (!aresetn || serial_select_n) begin
            rise_q <= 7'h00;
        end else if (serial_clk && !sclk_q) begin
            rise_q <= rise_q + 7'h01;
        end
    end

    always_ff @(posedge aclk) begin
        sclk_q <= aresetn ? serial_clk : 1'b0;
    end

    sequence s_frame_open;
        $fell(serial_select_n);
    endsequence

    sequence s_sclk_high;
        serial_clk [*4] ##1 !serial_clk;
    endsequence

    a_sclk_idle_low: assert property (serial_select_n |-> !serial_clk)
        else $error("serial clock moved outside a frame");
    a_sclk_half_per: assert property ($rose(serial_clk) |-> s_sclk_high)
        else $error("serial clock high phase wrong length");
    a_data_hold_high: assert property (serial_clk |-> $stable(serial_input_line))
        else $error("serial data changed while clock high");
    a_header_first: assert property (s_frame_open |-> !serial_input_line)
        else $error("frame does not open with a zero");
    a_first_rise: assert property (s_frame_open |-> ##[3:5] $rose(serial_clk))
        else $error("first serial clock rise late");
    a_frame_bits: assert property ($rose(serial_select_n) |-> rise_q == 7'h20)
        else $error("frame did not carry 32 bits");
    a_resync_no_cal: assert property ($rose(out_clock_resync) |-> !$past(calibration_running))
        else $error("resync raised during calibration");
    a_frame_no_cal: assert property (s_frame_open |-> !$past(calibration_running, 2))
        else $error("frame started during calibration");
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Purpose: self-checking bench for host and device over the trim link
// Assumes: bench is the AXI4-Lite master, aclk at 40 MHz
// Notes:   partial frames are not injected, kept out for size
`timescale 1ns/1ps
`default_nettype none
module tb;
    import atrc_pkg::*;
    logic        aclk, aresetn, calibrate_start;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic        extended_mode, range_select_pin, output_edge_select;
    logic [9:0]  sample_in;
    logic [7:0]  offset_magnitude, data_out;
    logic        offset_negative, full_scale_from_pin, out_of_range, data_clock_output;
    logic [8:0]  full_scale_code;
    int          error_cnt, tests_run;

    atrc_link_if link_if();
    atrc_device atrc_device_inst (.aclk, .aresetn, .link(link_if), .extended_mode,
        .range_select_pin, .output_edge_select, .calibrate_start, .sample_in,
        .offset_magnitude, .offset_negative, .full_scale_code, .full_scale_from_pin,
        .data_out, .out_of_range, .data_clock_output);
    atrc_host atrc_host_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .link(link_if));
    atrc_chk atrc_chk_inst (.aclk(aclk), .aresetn(aresetn),
        .serial_clk(link_if.serial_clk), .serial_input_line(link_if.serial_input_line),
        .serial_select_n(link_if.serial_select_n),
        .out_clock_resync(link_if.out_clock_resync),
        .calibration_running(link_if.calibration_running));

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    task automatic summarize();
        $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic hang(input string nm);
        error_cnt++;
        $display("[ERR] %s expected done seen timeout", nm);
        summarize();
    endtask

    // Ready sampled just after the edge, stable until the next one
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        logic aw, w, b;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (int n = 0; n < 64; n++) begin
            #1;
            aw   = s_axi_awvalid && s_axi_awready;
            w    = s_axi_wvalid && s_axi_wready;
            b    = s_axi_bvalid && s_axi_bready;
            resp = s_axi_bresp;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) begin
                s_axi_bready <= 1'b0;
                return;
            end
        end
        hang("write");
    endtask

    task automatic axi_rd(input logic [3:0] a);
        logic ar, r;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (int n = 0; n < 64; n++) begin
            #1;
            ar   = s_axi_arvalid && s_axi_arready;
            r    = s_axi_rvalid && s_axi_rready;
            rd   = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 1'b0;
            if (r) begin
                s_axi_rready <= 1'b0;
                return;
            end
        end
        hang("read");
    endtask

    // Busy drops a few cycles after the device has taken the frame
    task automatic wait_idle();
        for (int n = 0; n < 400; n++) begin
            axi_rd(AXI_STATUS);
            if (rd[0] === 1'b0) begin
                repeat (8) @(posedge aclk);
                return;
            end
        end
        hang("busy");
    endtask

    task automatic t_offset(input logic [7:0] m, input logic s);
        axi_wr(AXI_OFFSET, {16'h0000, m, s, 7'h00});
        chk("offset bresp", RESP_OKAY, resp);
        axi_wr(AXI_CTRL, 32'h00000001);
        wait_idle();
        chk("offset_magnitude", m, offset_magnitude);
        chk("offset_negative", s, offset_negative);
        $display("test offset %h sign %b done", m, s);
    endtask

    task automatic t_full(input logic [8:0] v, input logic [8:0] e);
        axi_wr(AXI_OFFSET, 32'h00005A00);
        axi_wr(AXI_FULLSCALE, {16'h0000, v, 7'h00});
        axi_wr(AXI_CTRL, 32'h00000003);
        wait_idle();
        chk("full_scale_code", e, full_scale_code);
        chk("offset_magnitude", 32'h5A, offset_magnitude);
        chk("calibration_running", 0, link_if.calibration_running);
        axi_rd(AXI_OFFSET);
        chk("offset readback", 32'h00005A7F, rd);
        $display("test full scale %h done", v);
    endtask

    task automatic t_data();
        logic [9:0] smp [6] = '{10'h000, 10'h07F, 10'h080, 10'h380, 10'h37F, 10'h3FF};
        logic [8:0] exp [6] = '{9'h080, 9'h0FF, 9'h1FF, 9'h000, 9'h100, 9'h07F};
        extended_mode <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            sample_in <= smp[i];
            repeat (4) @(posedge aclk);
            chk("data_out", exp[i][7:0], data_out);
            chk("out_of_range", exp[i][8], out_of_range);
        end
        chk("full_scale_from_pin", 1, full_scale_from_pin);
        chk("offset_magnitude normal", 0, offset_magnitude);
        chk("full_scale_code normal", FS_NOMINAL, full_scale_code);
        extended_mode <= 1'b1;
        @(posedge aclk);
        #1;
        chk("full_scale_from_pin", 0, full_scale_from_pin);
        $display("test data path done");
    endtask

    task automatic t_resync();
        logic seen;
        axi_wr(AXI_CTRL, 32'h00000004);
        repeat (4) @(posedge aclk);
        chk("out_clock_resync", 1, link_if.out_clock_resync);
        for (int i = 0; i < 6; i++) begin
            @(posedge aclk);
            #1;
            chk("data_clock_output held", 0, data_clock_output);
        end
        axi_wr(AXI_CTRL, 32'h00000000);
        seen = 1'b0;
        for (int i = 0; i < 12; i++) begin
            @(posedge aclk);
            #1;
            if (data_clock_output === 1'b1) seen = 1'b1;
        end
        chk("data clock restart", 1, seen);
        $display("test resync done");
    endtask

    task automatic t_cal();
        @(posedge aclk);
        calibrate_start <= 1'b1;
        @(posedge aclk);
        calibrate_start <= 1'b0;
        // Host sees calibration only after its synchroniser
        repeat (3) @(posedge aclk);
        axi_wr(AXI_CTRL, 32'h00000005);
        axi_rd(AXI_STATUS);
        chk("status calibrating", 1, rd[1]);
        chk("status refused", 1, rd[2]);
        chk("out_clock_resync", 0, link_if.out_clock_resync);
        chk("serial_select_n", 1, link_if.serial_select_n);
        axi_rd(4'h6);
        chk("unmapped rresp", RESP_SLVERR, resp);
        repeat (20) @(posedge aclk);
        chk("calibration_running", 0, link_if.calibration_running);
        $display("test calibration guard done");
    endtask

    initial begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 4'h0;
        s_axi_araddr = 4'h0;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'hF;
        extended_mode = 1'b1;
        range_select_pin = 1'b1;
        output_edge_select = 1'b0;
        calibrate_start = 1'b0;
        sample_in = 10'h000;
        error_cnt = 0;
        tests_run = 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("offset_magnitude", 0, offset_magnitude);
        chk("offset_negative", 0, offset_negative);
        chk("full_scale_code", FS_NOMINAL, full_scale_code);
        $display("test reset values done");
        t_offset(8'hFF, 1'b1);
        t_offset(8'h00, 1'b0);
        t_offset(8'h00, 1'b1);
        t_full(9'h0E0, 9'h0E0);
        t_full(9'h1FF, FS_LIMIT_HI);
        t_full(9'h000, FS_LIMIT_LO);
        t_data();
        t_resync();
        t_cal();
        summarize();
    end
endmodule
`default_nettype wire
